// ===== core/mcs_pkg.sv
// Constants and types shared by the machine cycle sequencer.
// Assumes a single fast system clock that samples the oscillator pin.
package mcs_pkg;

  localparam int CLK_MHZ = 250;
  localparam logic [2:0] STATE_FIRST = 3'h0;
  localparam logic [2:0] STATE_LAST = 3'h5;
  localparam logic [2:0] STATE_S4 = 3'h3;
  localparam logic [2:0] STATE_S3 = 3'h2;
  localparam logic [1:0] CYC_ONE = 2'h0;
  localparam logic [1:0] CYC_TWO = 2'h1;
  localparam logic [1:0] CYC_FOUR = 2'h3;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [2:0] {
    EXEC_IDLE = 3'b001,
    EXEC_RUN = 3'b010,
    EXEC_XMOVE = 3'b100
  } exec_state_t;

  // Decoded instruction shape supplied with each opcode.
  typedef struct packed {
    logic [1:0] byte_count;
    logic [1:0] cycle_count;
    logic ext_move;
    logic ext_target;
    logic mul_div;
  } instr_shape_t;

  // Timing position inside a machine cycle.
  typedef struct packed {
    logic [2:0] state;
    logic phase2;
    logic period_pulse;
  } timing_t;

endpackage

// ===== core/osc_divider.sv
// Halves the synchronised oscillator and marks each edge of the halved clock as a period.
// Assumes osc_sync_i is already synchronised to clk_i.
`timescale 1ns/10ps
module osc_divider
  import mcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Oscillator level and derived enable.
  input wire logic osc_sync_i,
  output logic period_en_o
);

  logic osc_prev_reg;
  logic half_reg;
  logic half_prev_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync_i;
    end
  end

  // divide by two.
  // Only rising edges count, so the input duty cycle is irrelevant.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_reg <= 1'b0;
    end else if (osc_sync_i && !osc_prev_reg) begin
      half_reg <= !half_reg;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_prev_reg <= 1'b0;
    end else begin
      half_prev_reg <= half_reg;
    end
  end

  // Both edges of the halved clock count, so each input period yields one pulse.
  assign period_en_o = half_reg ^ half_prev_reg;

endmodule

// ===== core/machine_cycle_sequencer.sv
// Machine cycle sequencer: state and phase timing, fetch and data access slots.
// Assumes an opcode decoder supplies the instruction shape with each fetched opcode.
// What this block does
// - Oscillator passes divide-by-two before timing.
// - State time is two periods, P1 then P2.
// - Machine cycle is six states, S1 to S6.
// - Periods counted S1P1 through S6P2 in order.
// - Arithmetic in phase 1, transfers in phase 2.
// - Instructions are one opcode plus up to two.
// - One, two, or four machine cycles per instruction.
// - Two code fetches per cycle at S1, S4, none in an external move's second cycle.
// - Opcode latched S1P2, execution ends S6P2.
// - One-byte: S4 byte discarded, counter holds.
// - Two-byte operand fetched at same-cycle S4.
// - Two-cycle: next opcode refetched and discarded.
// - External move accesses from S4 to S3.
// - External target enables ports and strobes.
// - Internal target uses internal bus, pins untouched.
// - Address latch strobe pulses twice per cycle.
`timescale 1ns/10ps
module machine_cycle_sequencer
  import mcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Oscillator pins.
  input wire logic osc_in_i,
  output logic osc_out_o,
  // Decoded instruction shape, valid with the opcode latch pulse.
  input wire instr_shape_t shape_i,
  input wire logic write_i,
  // Timing outputs.
  output timing_t timing_o,
  output logic alu_en_o,
  output logic xfer_en_o,
  // Fetch control.
  output logic code_fetch_o,
  output logic opcode_latch_o,
  output logic operand_take_o,
  output logic byte_discard_o,
  output logic pc_inc_o,
  output logic instr_done_o,
  output logic address_latch_strobe_o,
  // Data access control.
  output logic data_active_o,
  output logic int_bus_en_o,
  output logic ext_bus_en_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o
);

  logic osc_s1_reg;
  logic osc_s2_reg;
  logic period_en;
  logic [2:0] state_reg;
  logic phase2_reg;
  exec_state_t exec_reg;
  logic [1:0] cyc_reg;
  logic [1:0] left_bytes_reg;
  instr_shape_t shape_reg;
  logic write_reg;
  logic data_reg;
  logic ext_en_reg;
  logic int_en_reg;
  logic ale_reg;
  logic wr_en_reg;
  logic at_s1;
  logic at_s4;
  logic end_cycle;
  logic last_cycle;
  logic [1:0] cycles_last;

  // The pin is asynchronous, so it passes two flops first.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_in_i;
      osc_s2_reg <= osc_s1_reg;
    end
  end

  osc_divider u_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .osc_sync_i(osc_s2_reg),
    .period_en_o(period_en)
  );

  assign osc_out_o = osc_s2_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= STATE_FIRST;
      phase2_reg <= 1'b0;
    end else if (period_en) begin
      phase2_reg <= !phase2_reg;
      if (phase2_reg) begin
        state_reg <= (state_reg == STATE_LAST) ? STATE_FIRST : 3'(state_reg + 3'h1);
      end
    end
  end

  assign timing_o = '{state: state_reg, phase2: phase2_reg, period_pulse: period_en};
  assign alu_en_o = period_en && !phase2_reg;
  assign xfer_en_o = period_en && phase2_reg;

  assign at_s1 = period_en && !phase2_reg && state_reg == STATE_FIRST;
  assign at_s4 = period_en && !phase2_reg && state_reg == STATE_S4;
  assign end_cycle = period_en && phase2_reg && state_reg == STATE_LAST;
  // four-cycle product ops.
  // Product and quotient ops stretch to four cycles regardless of the decoded count.
  assign cycles_last = shape_reg.mul_div ? CYC_FOUR : shape_reg.cycle_count;
  assign last_cycle = (exec_reg == EXEC_IDLE) || (cyc_reg == cycles_last);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exec_reg <= EXEC_IDLE;
      cyc_reg <= CYC_ONE;
      shape_reg <= '0;
      write_reg <= 1'b0;
    end else if (opcode_latch_o) begin
      shape_reg <= shape_i;
      write_reg <= write_i;
      cyc_reg <= CYC_ONE;
      exec_reg <= shape_i.ext_move ? EXEC_XMOVE : EXEC_RUN;
    end else if (end_cycle) begin
      cyc_reg <= 2'(cyc_reg + 2'h1);
      if (last_cycle) begin
        exec_reg <= EXEC_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_bytes_reg <= 2'h0;
    end else if (opcode_latch_o) begin
      left_bytes_reg <= 2'(shape_i.byte_count - LEN_ONE);
    end else if (operand_take_o) begin
      left_bytes_reg <= 2'(left_bytes_reg - 2'h1);
    end
  end

  // fetches at S1 and S4.
  // Fetch is suppressed in the external move's second cycle to free the bus.
  assign code_fetch_o = (at_s1 || at_s4) && !(exec_reg == EXEC_XMOVE && cyc_reg == CYC_TWO);
  // opcode latched at S1P2 on a fresh cycle.
  assign opcode_latch_o = period_en && phase2_reg && state_reg == STATE_FIRST
                          && (exec_reg == EXEC_IDLE);
  assign operand_take_o = code_fetch_o && left_bytes_reg != 2'h0 && !at_s1
                          || code_fetch_o && at_s1 && exec_reg != EXEC_IDLE
                          && left_bytes_reg != 2'h0;
  assign byte_discard_o = code_fetch_o && !operand_take_o && !(at_s1 && exec_reg == EXEC_IDLE);
  assign pc_inc_o = code_fetch_o && !byte_discard_o;
  assign instr_done_o = end_cycle && exec_reg != EXEC_IDLE && last_cycle;

  // data window S4 to S3.
  // The window opens as S3 of the first cycle ends and closes as S3 of the second ends.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_reg <= 1'b0;
    end else if (period_en && phase2_reg && exec_reg == EXEC_XMOVE
                 && state_reg == STATE_S3) begin
      if (cyc_reg == CYC_ONE) begin
        data_reg <= 1'b1;
      end else if (cyc_reg == CYC_TWO) begin
        data_reg <= 1'b0;
      end
    end else if (exec_reg != EXEC_XMOVE) begin
      data_reg <= 1'b0;
    end
  end

  // Bus enables, address strobe and write strobe are registered so those pins never glitch on decode.
  // external enables.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_en_reg <= 1'b0;
    end else begin
      ext_en_reg <= data_reg && shape_reg.ext_target;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_en_reg <= 1'b0;
    end else begin
      int_en_reg <= data_reg && !shape_reg.ext_target;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ale_reg <= 1'b0;
    end else begin
      ale_reg <= (state_reg == STATE_FIRST || state_reg == STATE_S4) && !phase2_reg;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_en_reg <= 1'b0;
    end else begin
      wr_en_reg <= data_reg && shape_reg.ext_target && write_reg;
    end
  end

  assign data_active_o = data_reg;
  assign ext_bus_en_o = ext_en_reg;
  assign int_bus_en_o = int_en_reg;
  assign address_latch_strobe_o = ale_reg;
  assign read_strobe_n_o = !(ext_en_reg && !wr_en_reg);
  assign write_strobe_n_o = !wr_en_reg;

endmodule

// ===== sim/mcs_sva.sv
// Timing checks on the sequencer's top-level ports.
// Assumes oscillator high and low times of at least two system clocks.
`timescale 1ns/10ps
module mcs_sva
  import mcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Watched outputs.
  input wire timing_t timing_o,
  input wire logic osc_out_o,
  input wire logic data_active_o,
  input wire logic code_fetch_o,
  input wire logic opcode_latch_o,
  input wire logic byte_discard_o,
  input wire logic pc_inc_o,
  input wire logic instr_done_o,
  input wire logic address_latch_strobe_o,
  input wire logic int_bus_en_o,
  input wire logic ext_bus_en_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o
);
  logic p1_slot;
  logic [2:0] st;
  assign st = timing_o.state;
  assign p1_slot = !timing_o.phase2 && (st == STATE_FIRST || st == STATE_S4);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_gap; timing_o.period_pulse |=> !timing_o.period_pulse [*3]; endproperty
  a_gap: assert property (p_gap) else $error("period pulses too close");
  property p_osc; $rose(osc_out_o) |=> timing_o.period_pulse; endproperty
  a_osc: assert property (p_osc) else $error("oscillator edge gave no period");
  property p_win; $changed(data_active_o) |-> st == STATE_S4 && !timing_o.phase2; endproperty
  a_win: assert property (p_win) else $error("data window edge off S4");
  property p_step; $changed(st) |-> !timing_o.phase2 &&
    st == (($past(st) == STATE_LAST) ? STATE_FIRST : $past(st) + 3'h1); endproperty
  a_step: assert property (p_step) else $error("bad state step");
  property p_fetch; code_fetch_o |-> ##[0:1] p1_slot; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch off slot");
  property p_latch; opcode_latch_o |-> ##[0:1] (timing_o.phase2 && st == STATE_FIRST); endproperty
  a_latch: assert property (p_latch) else $error("latch off slot");
  property p_done; instr_done_o |-> ##[0:1] (timing_o.phase2 && st == STATE_LAST); endproperty
  a_done: assert property (p_done) else $error("done off slot");
  property p_disc; byte_discard_o |-> code_fetch_o && !pc_inc_o; endproperty
  a_disc: assert property (p_disc) else $error("discard advanced count");
  property p_ale; $rose(address_latch_strobe_o) |-> ##[0:2] p1_slot; endproperty
  a_ale: assert property (p_ale) else $error("strobe off slot");
  property p_int; int_bus_en_o |-> !ext_bus_en_o && read_strobe_n_o && write_strobe_n_o;
  endproperty
  a_int: assert property (p_int) else $error("pins moved on inner access");
endmodule

// ===== sim/osc_source.sv
// Oscillator pin source with settable high and low counts.
// Assumes counts of at least two system clocks.
`timescale 1ns/10ps
module osc_source (
  // Clock and duty setting.
  input wire logic clk_i,
  input wire logic [3:0] hi_i,
  input wire logic [3:0] lo_i,
  // Oscillator pin.
  output logic osc_o
);
  logic [3:0] n_reg = 4'h0;
  initial osc_o = 1'b0;
  always @(negedge clk_i) begin
    if (n_reg + 4'h1 >= (osc_o ? hi_i : lo_i)) begin
      osc_o <= !osc_o;
      n_reg <= 4'h0;
    end else begin
      n_reg <= n_reg + 4'h1;
    end
  end
endmodule

// ===== sim/machine_cycle_sequencer_tb.sv
// Self-checking bench: counts port events between instruction ends.
// Assumes osc_source and mcs_sva are compiled first.
`timescale 1ns/10ps
module machine_cycle_sequencer_tb
  import mcs_pkg::*;
;
  logic clk_i = 0, nrst_i = 0, write_i = 0, clr = 0, osc_in_i, osc_out_o, alu_en_o, xfer_en_o;
  logic code_fetch_o, opcode_latch_o, operand_take_o, byte_discard_o, pc_inc_o, instr_done_o;
  logic address_latch_strobe_o, data_active_o, int_bus_en_o, ext_bus_en_o;
  logic read_strobe_n_o, write_strobe_n_o;
  logic [3:0] hi = 4'h2, lo = 4'h2;
  instr_shape_t shape_i = '0;
  timing_t timing_o;
  logic [31:0] cnt [14];
  logic [13:0] ev;
  int err_total = 0, n_tests = 0;
  assign ev = {address_latch_strobe_o, xfer_en_o, alu_en_o, !read_strobe_n_o, !write_strobe_n_o,
    int_bus_en_o, ext_bus_en_o, data_active_o, pc_inc_o, operand_take_o, byte_discard_o,
    code_fetch_o, opcode_latch_o, 1'b1};
  always @(posedge clk_i) for (int i = 0; i < 14; i++) cnt[i] <= clr ? 32'h0 : cnt[i] + ev[i];
  initial begin
    forever #2 clk_i = !clk_i;
  end
  osc_source osc_u(.clk_i, .hi_i(hi), .lo_i(lo), .osc_o(osc_in_i));
  machine_cycle_sequencer dut_u(.clk_i, .nrst_i, .osc_in_i, .osc_out_o, .shape_i, .write_i,
    .timing_o, .alu_en_o, .xfer_en_o, .code_fetch_o, .opcode_latch_o, .operand_take_o,
    .byte_discard_o, .pc_inc_o, .instr_done_o, .address_latch_strobe_o, .data_active_o,
    .int_bus_en_o, .ext_bus_en_o, .read_strobe_n_o, .write_strobe_n_o);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (instr_done_o !== 1'b1 && k < 4000) begin
      @(negedge clk_i);
      k++;
    end
    check({31'h0, k < 4000}, 32'h1);
  endtask
  // Counts cover one whole instruction, less its final clock.
  task automatic measure(input instr_shape_t s, input logic w);
    shape_i = s;
    write_i = w;
    @(negedge clk_i);
    wait_done();
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    wait_done();
  endtask
  task automatic row(input logic [31:0] e [9]);
    for (int i = 0; i < 9; i++) check(cnt[i], e[i]);
  endtask
  task automatic t_one();
    measure('{LEN_ONE, CYC_ONE, 1'b0, 1'b0, 1'b0}, 1'b0);
    row('{47, 1, 2, 1, 0, 1, 0, 0, 0});
    check(cnt[11], 32'h6);
    check(cnt[12], 32'h5);
    check(cnt[13], 32'h8);
  endtask
  task automatic t_two();
    measure('{LEN_TWO, CYC_ONE, 1'b0, 1'b0, 1'b0}, 1'b0);
    row('{47, 1, 2, 0, 1, 2, 0, 0, 0});
    measure('{LEN_THREE, CYC_TWO, 1'b0, 1'b0, 1'b0}, 1'b0);
    row('{95, 1, 4, 1, 2, 3, 0, 0, 0});
  endtask
  task automatic t_long();
    measure('{LEN_ONE, CYC_TWO, 1'b0, 1'b0, 1'b0}, 1'b0);
    row('{95, 1, 4, 3, 0, 1, 0, 0, 0});
    measure('{LEN_ONE, CYC_ONE, 1'b0, 1'b0, 1'b1}, 1'b0);
    row('{191, 1, 8, 7, 0, 1, 0, 0, 0});
  endtask
  task automatic t_xmove();
    measure('{LEN_ONE, CYC_TWO, 1'b1, 1'b1, 1'b0}, 1'b1);
    row('{95, 1, 2, 1, 0, 1, 48, 48, 0});
    check(cnt[9], 32'h30);
    check(cnt[10], 32'h0);
    measure('{LEN_ONE, CYC_TWO, 1'b1, 1'b1, 1'b0}, 1'b0);
    row('{95, 1, 2, 1, 0, 1, 48, 48, 0});
    check(cnt[10], 32'h30);
    check(cnt[9], 32'h0);
    measure('{LEN_ONE, CYC_TWO, 1'b1, 1'b0, 1'b0}, 1'b0);
    row('{95, 1, 2, 1, 0, 1, 48, 0, 48});
    check(cnt[10] | cnt[9], 32'h0);
  endtask
  // A lopsided duty must still give two-edge periods.
  task automatic t_duty();
    lo <= 4'h6;
    measure('{LEN_ONE, CYC_ONE, 1'b0, 1'b0, 1'b0}, 1'b0);
    check(cnt[0], 32'h5f);
    lo <= 4'h2;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    t_one();
    t_two();
    t_long();
    t_xmove();
    t_duty();
    print_verdict();
  end
  initial begin
    #60000;
    err_total++;
    print_verdict();
  end
endmodule
bind machine_cycle_sequencer mcs_sva sva_u(.clk_i, .nrst_i, .timing_o, .osc_out_o, .data_active_o,
  .code_fetch_o,
  .opcode_latch_o, .byte_discard_o, .pc_inc_o, .instr_done_o, .address_latch_strobe_o,
  .int_bus_en_o, .ext_bus_en_o, .read_strobe_n_o, .write_strobe_n_o);
